// file: scsc_clk_div.sv
/*
  Clock divider: builds the processor, half-duty and peripheral clock levels from the
  source clock (sys_clk_i stands for the crystal or external frequency input).
  Assumes the sequencer drives run_i, slow_i and hold_high_i synchronously.
*/
`timescale 1ns/1ns
`include "scsc_consts.svh"

module scsc_clk_div (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic run_i,
  input wire logic slow_i,
  input wire logic hold_high_i,
  output logic cyc_end_o,
  output logic pclk_rise_o,
  output logic proc_clk_o,
  output logic half_duty_clock_o,
  output logic pclk_o
);
  import scsc_pkg::*;

  // Period in source cycles for the selected speed
  function automatic scsc_phase_t period_of(input logic slow);
    period_of = slow ? scsc_phase_t'(`SCSC_FAST_PERIOD * `SCSC_SLOW_MULT) : `SCSC_FAST_PERIOD;
  endfunction : period_of

  scsc_phase_t fc_q; // Position inside the current processor period
  scsc_phase_t fc_d;
  scsc_phase_t period; // Length of the current period
  logic last; // Final source cycle of the period
  logic proc_d;
  logic half_d;

  assign period = period_of(slow_i);
  assign last = (fc_q >= period - 10'h001);
  assign cyc_end_o = run_i && last;
  assign pclk_rise_o = cyc_end_o && !pclk_o;
  // Restart at zero so a resumed clock begins with its high third
  assign fc_d = (!run_i || last) ? '0 : fc_q + 10'h001;
  // High third for the processor clock, half for the half-duty clock
  // Fast mode has one source cycle of resolution, so its half-duty high is 2 of 3 cycles
  assign proc_d = run_i ? (fc_d < period / 10'h003) : (hold_high_i | proc_clk_o);
  assign half_d = run_i ? (fc_d < (period + 10'h001) / 10'h002)
                        : (hold_high_i | half_duty_clock_o);

  // Phase counter and clock levels
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      fc_q <= '0;
      proc_clk_o <= 1'b1;
      half_duty_clock_o <= 1'b1;
    end
    else
    begin
      fc_q <= fc_d;
      proc_clk_o <= proc_d;
      half_duty_clock_o <= half_d;
    end
  end

  // Peripheral clock toggles once per processor period: half its rate
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      pclk_o <= 1'b1;
    else if (cyc_end_o)
      pclk_o <= !pclk_o;
    else if (!run_i && hold_high_i)
      pclk_o <= 1'b1;
  end

endmodule : scsc_clk_div

// file: scsc_clock_ctrl.sv
/*
  Clock controller top: start/stop sequencing, oscillator stabilisation wait, reset
  stretching and speed selection for a static system clock generator.
  Assumes all inputs are synchronous to sys_clk_i, which is the oscillator or external
  frequency itself; osc_valid_i reports the crystal amplitude reaching its threshold.
*/
`timescale 1ns/1ns
`include "scsc_consts.svh"

module scsc_clock_ctrl (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic freq_src_sel_i,
  input wire logic osc_valid_i,
  input wire logic reset_request_in_n_i,
  input wire logic start_i,
  input wire logic stop_status_line_n_i,
  input wire logic speed_select_i,
  output logic proc_clk_o,
  output logic half_duty_clock_o,
  output logic pclk_o,
  output logic reset_o,
  output scsc_pkg::scsc_state_t state_o
);
  import scsc_pkg::*;

  scsc_state_t state_q; // Sequencer state
  scsc_state_t state_d;
  logic [`SCSC_OSC_CNT_W-1:0] osc_cnt_q; // Valid oscillator cycles seen
  logic [`SCSC_RST_CNT_W-1:0] rst_cnt_q; // Processor cycles since reset release
  logic [1:0] stop_cnt_q; // Processor cycles since the stop command
  logic slow_q; // Speed in effect: high means slow
  logic reset_q;
  logic rst_armed_q; // A whole processor period has begun since the request went away
  logic req_active; // Reset request asserted
  logic stop_cmd; // Stop command on the status line
  logic run; // Divider running
  logic hold_high; // Stopped clocks are forced high
  logic cyc_end; // Last source cycle of a processor period
  logic pclk_rise; // Peripheral clock about to rise
  logic osc_done; // Stabilisation count complete
  logic stop_done; // Stop delay elapsed at a period end
  logic osc_count_en;

  assign req_active = !reset_request_in_n_i;
  assign stop_cmd = !stop_status_line_n_i;
  assign run = (state_q == ST_RUN) || (state_q == ST_STOP_PEND);
  // Crystal mode always parks high; waiting for the oscillator too
  assign hold_high = !freq_src_sel_i || (state_q == ST_OSC_WAIT);
  // Count only with a usable oscillator and the request released
  assign osc_count_en = (state_q == ST_OSC_WAIT) && osc_valid_i && !req_active;
  assign osc_done = osc_count_en && (osc_cnt_q == `SCSC_OSC_STABILISE_CYC - 14'h0001);
  // Halting at a period end leaves the processor clock in its high third
  assign stop_done = cyc_end && (stop_cnt_q == `SCSC_STOP_DELAY_CYC - 2'h1);
  assign state_o = state_q;
  assign reset_o = reset_q;

  // Next state: requests are taken at the edge where they are seen
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_OSC_WAIT:
        if (osc_done)
          state_d = ST_RUN;
      ST_RUN:
        if (stop_cmd)
          state_d = ST_STOP_PEND;
      ST_STOP_PEND:
        if (stop_done)
          state_d = ST_STOPPED;
      ST_STOPPED:
        // Crystal mode restart by reset waits out the oscillator again
        if (req_active && !freq_src_sel_i)
          state_d = ST_OSC_WAIT;
        else if (req_active || start_i)
          state_d = ST_RUN;
    endcase
  end

  // State register; crystal mode begins with the oscillator assumed stopped
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      state_q <= ST_OSC_WAIT;
    else
      state_q <= state_d;
  end

  // Oscillator stabilisation counter
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      osc_cnt_q <= '0;
    else if (state_q != ST_OSC_WAIT || req_active)
      osc_cnt_q <= '0;
    else if (osc_count_en)
      osc_cnt_q <= osc_cnt_q + 14'h0001;
  end

  // Stop delay counter, processor period ends, the first possibly partial
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      stop_cnt_q <= '0;
    else if (state_q != ST_STOP_PEND)
      stop_cnt_q <= '0;
    else if (cyc_end)
      stop_cnt_q <= stop_cnt_q + 2'h1;
  end

  // Speed change only lands on a peripheral clock rising edge; a late change waits
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      slow_q <= 1'b0;
    else if (pclk_rise)
      slow_q <= !speed_select_i;
  end

  // Reset stretch: held while requested, then 16 whole running processor periods.
  // The period already under way at release is skipped, else the output could drop
  // after only 15 periods; a stopped divider restarts with a whole period.
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      reset_q <= 1'b1;
      rst_cnt_q <= '0;
      rst_armed_q <= 1'b0;
    end
    else if (req_active)
    begin
      reset_q <= 1'b1;
      rst_cnt_q <= '0;
      rst_armed_q <= 1'b0;
    end
    else if (!run || (reset_q && cyc_end && !rst_armed_q))
      rst_armed_q <= 1'b1;
    else if (reset_q && cyc_end)
    begin
      rst_cnt_q <= rst_cnt_q + 5'h01;
      reset_q <= (rst_cnt_q != `SCSC_RESET_STRETCH_CYC - 5'h01);
    end
  end

  scsc_clk_div u_div (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .run_i(run),
    .slow_i(slow_q),
    .hold_high_i(hold_high),
    .cyc_end_o(cyc_end),
    .pclk_rise_o(pclk_rise),
    .proc_clk_o(proc_clk_o),
    .half_duty_clock_o(half_duty_clock_o),
    .pclk_o(pclk_o)
  );

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  a_crystal_stop_high: assert property (
    (state_q == ST_STOPPED && !freq_src_sel_i) |-> (proc_clk_o && half_duty_clock_o))
    else $error("crystal mode stopped clocks not high");

  a_efi_stop_frozen: assert property (
    (state_q == ST_STOPPED && $past(state_q == ST_STOPPED) && freq_src_sel_i)
      |-> ($stable(proc_clk_o) && $stable(half_duty_clock_o)))
    else $error("stopped clocks moved in external input mode");

  a_osc_wait_high: assert property (
    (state_q == ST_OSC_WAIT && $past(state_q == ST_OSC_WAIT))
      |-> (proc_clk_o && half_duty_clock_o && pclk_o))
    else $error("clocks not held high during oscillator wait");

  a_osc_wait_len: assert property (
    (state_q == ST_OSC_WAIT) ##1 (state_q == ST_RUN)
      |-> $past(osc_cnt_q, 1) == `SCSC_OSC_STABILISE_CYC - 14'h0001)
    else $error("started before 8192 oscillator cycles");

  a_reset_stretch: assert property (
    $fell(reset_q) |-> ($past(rst_cnt_q) == `SCSC_RESET_STRETCH_CYC - 5'h01))
    else $error("reset output released early");

  a_osc_gate: assert property (
    (state_q == ST_OSC_WAIT && !osc_valid_i) |=> (osc_cnt_q <= $past(osc_cnt_q)))
    else $error("stabilisation count moved below threshold");

  a_speed_on_edge: assert property (
    (slow_q != $past(slow_q)) |-> $past(pclk_rise))
    else $error("speed changed off a peripheral clock edge");

  sequence s_req_seen;
    req_active;
  endsequence

  a_request_next: assert property (
    s_req_seen |=> reset_q)
    else $error("reset request not recognised at next edge");

  sequence s_stop_taken;
    (state_q == ST_RUN) && stop_cmd;
  endsequence

  a_stop_high: assert property (
    s_stop_taken |=> (state_q == ST_STOP_PEND) ##[1:72] (state_q == ST_STOPPED && proc_clk_o))
    else $error("processor clock not stopped high in time");

  a_period_start: assert property (
    (run && cyc_end && state_d != ST_STOPPED) |=> (proc_clk_o && half_duty_clock_o))
    else $error("period did not start high");

endmodule : scsc_clock_ctrl

// file: scsc_consts.svh
/*
  Constants for the static clock start/stop/reset controller: counts, widths, period and slow factor.
  Assumes inclusion by scsc_pkg.sv and the design modules, by bare name.
*/
// Functional notes
// - Crystal mode stop halts clocks high
// - External input mode stop freezes clocks anywhere; the code halts at a period end, processor and half-duty clocks high
// - Crystal start waits release plus 8192 cycles
// - Reset output stays high 16 clock cycles
// - Stabilisation count starts at oscillator threshold
// - Speed select taken on peripheral clock edges
// - Requests sampled synchronously, recognised next edge
// - Stop command halts clock high within three
`ifndef SCSC_CONSTS_SVH
`define SCSC_CONSTS_SVH

// Valid oscillator cycles counted before a crystal start
`define SCSC_OSC_STABILISE_CYC 14'h2000
`define SCSC_OSC_CNT_W 14
// Processor clock cycles the reset output is stretched
`define SCSC_RESET_STRETCH_CYC 5'h10
`define SCSC_RST_CNT_W 5
// Processor period ends, the first possibly partial, between a stop command and the halt
`define SCSC_STOP_DELAY_CYC 2'h2
// Source cycles in one fast processor clock period
`define SCSC_FAST_PERIOD 10'h003
// Slow mode multiplies the fast processor clock period by this factor
`define SCSC_SLOW_MULT 10'h008
`define SCSC_FC_W 10

`endif

// file: scsc_cpu_model.sv
/*
  Processor-side model: counts whole processor clock cycles seen while reset is held.
  Assumes clocks and reset come straight from the controller outputs.
*/
`timescale 1ns/1ns
module scsc_cpu_model (
  input wire logic proc_clk_i,
  input wire logic reset_i,
  output logic [7:0] rst_clks_o
);
  logic seen_q = 1'b0; // Reset level at the previous fall
  initial rst_clks_o = 8'h00;
  // Each fall closes the high phase of one cycle, so a clock held high from the start
  // still counts its first cycle; sample just after it so the launch edges cannot race
  always @(negedge proc_clk_i)
  begin
    #1;
    if (reset_i)
      rst_clks_o <= seen_q ? rst_clks_o + 8'h01 : 8'h01;
    seen_q <= reset_i;
  end
endmodule : scsc_cpu_model

// file: scsc_pkg.sv
/*
  Types shared by the clock controller modules.
  Assumes scsc_consts.svh is on the include path.
*/
`include "scsc_consts.svh"

package scsc_pkg;

  // Sequencer states of the controller
  typedef enum logic [1:0] {
    ST_OSC_WAIT,
    ST_RUN,
    ST_STOP_PEND,
    ST_STOPPED
  } scsc_state_t;

  // Source-cycle phase counter
  typedef logic [`SCSC_FC_W-1:0] scsc_phase_t;

endpackage : scsc_pkg

// file: test_static_clock_start_stop_reset.sv
/*
  Self-checking bench: start-up wait, reset stretch, division, speed change, stops.
  Assumes the controller, its package and the processor model are compiled first.
*/
`timescale 1ns/1ns
module test_static_clock_start_stop_reset;
  import scsc_pkg::*;
  logic sys_clk = 1'b0; // 125 MHz source
  logic reset = 1'b1;
  logic src_sel = 1'b0; // Crystal mode first
  logic osc_ok = 1'b0;
  logic req_n = 1'b0;
  logic start = 1'b0;
  logic stop_n = 1'b1;
  logic speed = 1'b1;
  logic proc_clk, half_clk, pclk, rst_out;
  scsc_state_t state;
  logic [7:0] rst_clks;
  logic [1:0] lv;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int per, hi;

  scsc_clock_ctrl scsc_clock_ctrl_i (.sys_clk_i(sys_clk), .reset_i(reset),
    .freq_src_sel_i(src_sel), .osc_valid_i(osc_ok), .reset_request_in_n_i(req_n),
    .start_i(start), .stop_status_line_n_i(stop_n), .speed_select_i(speed),
    .proc_clk_o(proc_clk), .half_duty_clock_o(half_clk), .pclk_o(pclk),
    .reset_o(rst_out), .state_o(state));
  scsc_cpu_model scsc_cpu_model_i (.proc_clk_i(proc_clk), .reset_i(rst_out),
    .rst_clks_o(rst_clks));

  // Free-running source clock
  initial
  begin
    forever #4 sys_clk = ~sys_clk;
  end

  // Hang guard; the two 8192-cycle start-ups dominate the run
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  task automatic check_val(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val

  task automatic check_state(input scsc_state_t exp);
    comparisons++;
    if (state !== exp)
    begin
      bad_count++;
      $display("ERROR state expected %s seen %s", exp.name(), state.name());
    end
  endtask : check_state

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc

  // Bounded wait; the caller judges where it ended
  task automatic wait_state(input scsc_state_t s, input int lim);
    int n;
    n = 0;
    while (state !== s && n < lim)
    begin
      cyc(1);
      n++;
    end
  endtask : wait_state

  function automatic logic pick(input int sel);
    return (sel == 0) ? proc_clk : (sel == 1) ? half_clk : pclk;
  endfunction : pick

  // Measures one whole period from a rise, in source cycles
  task automatic check_clk(input int sel, input logic [7:0] eper, input logic [7:0] ehi);
    per = 0;
    hi = 0;
    while (pick(sel) !== 1'b0 && per < 99)
    begin
      cyc(1);
      per++;
    end
    while (pick(sel) !== 1'b1 && hi < 99)
    begin
      cyc(1);
      hi++;
    end
    hi = 0;
    while (pick(sel) === 1'b1 && hi < 99)
    begin
      cyc(1);
      hi++;
    end
    per = hi;
    while (pick(sel) === 1'b0 && per < 99)
    begin
      cyc(1);
      per++;
    end
    check_val("period", eper, 8'(per));
    check_val("high time", ehi, 8'(hi));
  endtask : check_clk

  // Reset must fall in bounded time, after at least 16 processor clocks
  task automatic rst_check();
    int n;
    n = 0;
    while (rst_out !== 1'b0 && n < 200)
    begin
      cyc(1);
      n++;
    end
    check_val("reset out", 8'h00, {7'h00, rst_out});
    check_val("reset stretch", 8'h01, {7'h00, rst_clks >= 8'h10});
  endtask : rst_check

  task automatic t_crystal_start();
    cyc(20);
    req_n = 1'b1;
    cyc(300);
    check_state(ST_OSC_WAIT);
    osc_ok = 1'b1;
    cyc(8100);
    check_state(ST_OSC_WAIT);
    check_val("held clocks", 8'h07, {5'h00, proc_clk, half_clk, pclk});
    wait_state(ST_RUN, 200);
    check_state(ST_RUN);
    check_val("reset out", 8'h01, {7'h00, rst_out});
    rst_check();
  endtask : t_crystal_start

  task automatic t_division();
    check_clk(0, 8'h03, 8'h01);
    check_clk(1, 8'h03, 8'h02);
    check_clk(2, 8'h06, 8'h03);
    speed = 1'b0;
    cyc(14);
    check_clk(0, 8'h18, 8'h08);
    check_clk(1, 8'h18, 8'h0C);
    speed = 1'b1;
    cyc(100);
    check_clk(0, 8'h03, 8'h01);
  endtask : t_division

  task automatic t_stop(input logic ext);
    src_sel = ext;
    cyc(5);
    stop_n = 1'b0;
    cyc(1);
    check_state(ST_STOP_PEND);
    wait_state(ST_STOPPED, 9);
    check_state(ST_STOPPED);
    stop_n = 1'b1;
    lv = ext ? {proc_clk, half_clk} : 2'h3;
    cyc(20);
    check_val("stopped clocks", {6'h00, lv}, {6'h00, proc_clk, half_clk});
    start = 1'b1;
    cyc(1);
    start = 1'b0;
    check_state(ST_RUN);
    check_clk(0, 8'h03, 8'h01);
  endtask : t_stop

  // Crystal stop, then a reset request: the oscillator wait is run again
  task automatic t_crystal_restart();
    src_sel = 1'b0;
    stop_n = 1'b0;
    wait_state(ST_STOPPED, 12);
    stop_n = 1'b1;
    req_n = 1'b0;
    cyc(1);
    check_state(ST_OSC_WAIT);
    req_n = 1'b1;
    cyc(8000);
    check_state(ST_OSC_WAIT);
    check_val("held clocks", 8'h07, {5'h00, proc_clk, half_clk, pclk});
    wait_state(ST_RUN, 400);
    check_state(ST_RUN);
    rst_check();
  endtask : t_crystal_restart

  task automatic t_reset_run();
    req_n = 1'b0;
    cyc(1);
    check_val("reset out", 8'h01, {7'h00, rst_out});
    req_n = 1'b1;
    rst_check();
    check_state(ST_RUN);
  endtask : t_reset_run

  // Inputs change only at falling edges; reset held 10 cycles
  initial
  begin
    cyc(10);
    reset = 1'b0;
    t_crystal_start();
    t_division();
    t_stop(1'b0);
    t_reset_run();
    t_stop(1'b1);
    t_crystal_restart();
    report_and_stop();
  end
endmodule : test_static_clock_start_stop_reset
